/* core/smwt_pkg.sv */
// Constants, types and helpers of the static memory write timing block
// Function
// - Address is presented before strobe transitions
// - Strobe obeys setup, pulse, hold sequence
// - Write chip select has own timing
// - Hold derives from programmed cycle length
// - Timings per chip select, in clocks
// - Zero setup keeps signal low back-to-back
// - Strobe mode drives data after strobe setup
// - Select mode drives data after select setup
// - Protect enable guards timing and mode
// - Protected write sets flag and source
// - Status read clears violation flag
// - Setup code: 128*bit5 plus low five
// - Pulse code: 256*bit6 plus low six
// - Cycle code: 256*top two plus low seven
// - Setup, pulse, cycle registers group fields
// - Setup and pulse reset to one
// - Cycle lengths reset to three
// - Both mode bits reset to one
// - Zero strobe hold in strobe mode still holds address, except before a back-to-back job on the same select
// - Read mode bit selects sample signal; the bit is only stored and read back here
package smwt_pkg;
    // Widths of the external write path
    localparam int SMWT_ADDR_W = 24;
    localparam int SMWT_DATA_W = 8;
    localparam int SMWT_CS_W   = 2;
    localparam int SMWT_NUM_CS = 4;
    localparam int SMWT_CNT_W  = 10;

    // Register byte offsets; chip select n sits at n*CS_STRIDE
    localparam logic [7:0] SMWT_OFS_SETUP  = 8'h00;
    localparam logic [7:0] SMWT_OFS_PULSE  = 8'h04;
    localparam logic [7:0] SMWT_OFS_CYCLE  = 8'h08;
    localparam logic [7:0] SMWT_OFS_MODE   = 8'h0C;
    localparam logic [7:0] SMWT_CS_STRIDE  = 8'h10;
    localparam logic [7:0] SMWT_OFS_WPMODE = 8'hE4;
    localparam logic [7:0] SMWT_OFS_WPSTAT = 8'hE8;

    // Field positions
    localparam int SMWT_WS_LSB   = 0;   // Write strobe setup/pulse
    localparam int SMWT_CSW_LSB  = 8;   // Write chip select setup/pulse
    localparam int SMWT_RS_LSB   = 16;  // Read strobe setup/pulse
    localparam int SMWT_CSR_LSB  = 24;  // Read chip select setup/pulse
    localparam int SMWT_WCYC_LSB = 0;   // Write cycle length
    localparam int SMWT_RCYC_LSB = 16;  // Read cycle length
    localparam int SMWT_RMODE_BIT = 0;
    localparam int SMWT_WMODE_BIT = 1;
    localparam int SMWT_WPROT_ENABLE_BIT  = 0;
    localparam int SMWT_WPVF_BIT  = 0;
    localparam int SMWT_WPSRC_LSB = 8;

    // Writable bits of each register
    localparam logic [31:0] SMWT_SETUP_MASK = 32'h3F3F3F3F;
    localparam logic [31:0] SMWT_PULSE_MASK = 32'h7F7F7F7F;
    localparam logic [31:0] SMWT_CYCLE_MASK = 32'h01FF01FF;
    localparam logic [31:0] SMWT_MODE_MASK  = 32'h00000003;

    // Reset values
    localparam logic [31:0] SMWT_SETUP_RST = 32'h01010101;
    localparam logic [31:0] SMWT_PULSE_RST = 32'h01010101;
    localparam logic [31:0] SMWT_CYCLE_RST = 32'h00030003;
    localparam logic [31:0] SMWT_MODE_RST  = 32'h00000003;

    // Engine states, one-hot
    typedef enum logic [2:0] {
        SMWT_IDLE = 3'b001,
        SMWT_RUN  = 3'b010,
        SMWT_EXT  = 3'b100
    } smwt_st_e;

    // One write request
    typedef struct packed {
        logic [SMWT_CS_W-1:0]   cs;
        logic [SMWT_ADDR_W-1:0] addr;
        logic [SMWT_DATA_W-1:0] data;
    } smwt_req_s;

    // Setup code to clocks
    function automatic logic [SMWT_CNT_W-1:0] smwt_set_eff(input logic [31:0] w, input int lsb);
        logic [5:0] f;
        f = w[lsb+:6];
        smwt_set_eff = {2'h0, f[5], 2'h0, f[4:0]};
    endfunction

    // Pulse code to clocks
    function automatic logic [SMWT_CNT_W-1:0] smwt_pul_eff(input logic [31:0] w, input int lsb);
        logic [6:0] f;
        f = w[lsb+:7];
        smwt_pul_eff = {1'h0, f[6], 2'h0, f[5:0]};
    endfunction

    // Cycle code to clocks
    function automatic logic [SMWT_CNT_W-1:0] smwt_cyc_eff(input logic [31:0] w, input int lsb);
        logic [8:0] f;
        f = w[lsb+:9];
        smwt_cyc_eff = {f[8:7], 1'h0, f[6:0]};
    endfunction
endpackage

/* core/smwt_top.sv */
// Write waveform engine and timing registers of the static memory controller
`timescale 1ns/10ps
`default_nettype none
module smwt_top
    import smwt_pkg::*;
#(
    parameter int NUM_CS = SMWT_NUM_CS
) (
    // Clock and reset
    input  wire logic                   CLK,
    input  wire logic                   RST_B,
    // Register port
    input  wire logic [7:0]             REG_ADDR,
    input  wire logic [31:0]            REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output logic      [31:0]            REG_RDATA,
    // Write requests from the system side
    input  wire logic                   WR_VALID,
    input  wire smwt_req_s              WR_REQ,
    output logic                        WR_READY,
    // External memory pins
    output logic      [SMWT_ADDR_W-1:0] MEM_ADDR,
    output logic      [SMWT_DATA_W-1:0] MEM_DATA_O,
    output logic                        MEM_DATA_OE,
    output logic                        MEM_WSTROBE_N,
    output logic      [NUM_CS-1:0]      MEM_CS_N
);
    // Timing registers, one word per chip select
    logic [NUM_CS-1:0][31:0] setup_r;       // Setup group
    logic [NUM_CS-1:0][31:0] pulse_r;       // Pulse group
    logic [NUM_CS-1:0][31:0] cycle_r;       // Cycle group
    logic [NUM_CS-1:0][31:0] mode_r;        // Mode bits
    logic                    wprot_enable_r;        // Protection enable
    logic                    wpvf_r;        // Violation flag
    logic [15:0]             wpsrc_r;       // Offending offset
    logic [31:0]             rdata_r;       // Read data stage

    // Engine state
    smwt_st_e                st_r, st_nxt;
    logic [SMWT_CNT_W-1:0]   c_r, c_nxt;     // Cycle position
    smwt_req_s               job_r, job_nxt; // Active write
    smwt_req_s               pend_r, pend_nxt; // Held across extension
    logic                    pv_r, pv_nxt;   // Pending valid
    logic                    rdy_r, rdy_nxt;
    logic                    wsn_r, wsn_nxt;
    logic [NUM_CS-1:0]       csn_r, csn_nxt;
    logic                    oe_r, oe_nxt;
    logic [SMWT_ADDR_W-1:0]  addr_r;
    logic [SMWT_DATA_W-1:0]  data_r;

    // Register decode
    logic                    cs_hit;        // Offset falls in a chip select bank
    logic [SMWT_CS_W-1:0]    reg_cs;
    logic [1:0]              reg_sel;
    logic                    prot_hit;      // Write aimed at a guarded register
    logic                    blk_wr;        // Write refused by protection

    assign reg_cs   = REG_ADDR[SMWT_CS_W+3:4];
    assign reg_sel  = REG_ADDR[3:2];
    assign cs_hit   = (REG_ADDR < 8'(NUM_CS * 16)) && (REG_ADDR[1:0] == 2'h0);
    assign prot_hit = REG_WR && cs_hit;
    assign blk_wr   = prot_hit && wprot_enable_r;

    // Timing of the active job (current cycle)
    logic [SMWT_CNT_W-1:0]   cur_ws, cur_wp, cur_cyc;
    logic                    cur_wm, last, ext, acc, same_cs;
    assign cur_ws  = smwt_set_eff(setup_r[job_r.cs], SMWT_WS_LSB);
    assign cur_wp  = smwt_pul_eff(pulse_r[job_r.cs], SMWT_WS_LSB);
    assign cur_cyc = smwt_cyc_eff(cycle_r[job_r.cs], SMWT_WCYC_LSB);
    assign cur_wm  = mode_r[job_r.cs][SMWT_WMODE_BIT];
    assign last    = (c_r + 10'h001) >= cur_cyc;
    // Zero strobe hold in strobe mode needs one extra hold clock
    assign ext     = cur_wm && ((cur_ws + cur_wp) >= cur_cyc);
    assign acc     = WR_VALID && rdy_r;
    assign same_cs = (WR_REQ.cs == job_r.cs);

    // Timing of the job seen at the next edge
    logic [SMWT_CNT_W-1:0]   n_ws, n_wp, n_cs, n_cp, n_cyc;
    logic                    n_wm;
    assign n_ws  = smwt_set_eff(setup_r[job_nxt.cs], SMWT_WS_LSB);
    assign n_wp  = smwt_pul_eff(pulse_r[job_nxt.cs], SMWT_WS_LSB);
    assign n_cs  = smwt_set_eff(setup_r[job_nxt.cs], SMWT_CSW_LSB);
    assign n_cp  = smwt_pul_eff(pulse_r[job_nxt.cs], SMWT_CSW_LSB);
    assign n_cyc = smwt_cyc_eff(cycle_r[job_nxt.cs], SMWT_WCYC_LSB);
    assign n_wm  = mode_r[job_nxt.cs][SMWT_WMODE_BIT];

    // Sequencer: next state, position and job
    always_comb begin
        st_nxt   = st_r;
        c_nxt    = c_r;
        job_nxt  = job_r;
        pend_nxt = pend_r;
        pv_nxt   = pv_r;
        case (st_r)
            SMWT_IDLE: begin
                // New job starts at position zero
                if (acc) begin
                    st_nxt  = SMWT_RUN;
                    c_nxt   = '0;
                    job_nxt = WR_REQ;
                end
            end
            SMWT_RUN: begin
                if (!last) begin
                    c_nxt = c_r + 10'h001;
                end else if (acc && (same_cs || !ext)) begin
                    // Back-to-back job; zero setup keeps lines low
                    c_nxt   = '0;
                    job_nxt = WR_REQ;
                end else if (ext) begin
                    st_nxt   = SMWT_EXT;
                    pend_nxt = WR_REQ;
                    pv_nxt   = acc;
                end else begin
                    st_nxt = SMWT_IDLE;
                end
            end
            SMWT_EXT: begin
                c_nxt = '0;
                if (pv_r) begin
                    st_nxt  = SMWT_RUN;
                    job_nxt = pend_r;
                    pv_nxt  = 1'b0;
                end else if (acc) begin
                    st_nxt  = SMWT_RUN;
                    job_nxt = WR_REQ;
                end else begin
                    st_nxt = SMWT_IDLE;
                end
            end
            default: begin
                st_nxt = SMWT_IDLE;
                pv_nxt = 1'b0;
            end
        endcase
    end

    // Waveform decode for the next position
    always_comb begin
        wsn_nxt = 1'b1;
        csn_nxt = '1;
        oe_nxt  = 1'b0;
        rdy_nxt = 1'b0;
        case (st_nxt)
            SMWT_RUN: begin
                // Low between end of setup and end of pulse; hold is the rest
                wsn_nxt = !((c_nxt >= n_ws) && (c_nxt < n_ws + n_wp));
                csn_nxt[job_nxt.cs] = !((c_nxt >= n_cs) && (c_nxt < n_cs + n_cp));
                // Data driven from end of the controlling setup to cycle end
                oe_nxt  = n_wm ? (c_nxt >= n_ws) : (c_nxt >= n_cs);
                rdy_nxt = (c_nxt + 10'h001) >= n_cyc;
            end
            SMWT_EXT: begin
                // Strobe up; select and data stay as they were
                csn_nxt = csn_r;
                oe_nxt  = oe_r;
                rdy_nxt = !pv_nxt;
            end
            SMWT_IDLE: begin
                rdy_nxt = 1'b1;
            end
            default: begin
                rdy_nxt = 1'b0;
            end
        endcase
    end

    // Engine registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r   <= SMWT_IDLE;
            c_r    <= '0;
            job_r  <= '0;
            pend_r <= '0;
            pv_r   <= 1'b0;
            rdy_r  <= 1'b1;
        end else begin
            st_r   <= st_nxt;
            c_r    <= c_nxt;
            job_r  <= job_nxt;
            pend_r <= pend_nxt;
            pv_r   <= pv_nxt;
            rdy_r  <= rdy_nxt;
        end
    end

    // Pin registers; address and data load with the job at position zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wsn_r  <= 1'b1;
            csn_r  <= '1;
            oe_r   <= 1'b0;
            addr_r <= '0;
            data_r <= '0;
        end else begin
            wsn_r  <= wsn_nxt;
            csn_r  <= csn_nxt;
            oe_r   <= oe_nxt;
            if (st_nxt == SMWT_RUN) begin
                addr_r <= job_nxt.addr;
                data_r <= job_nxt.data;
            end
        end
    end

    // Timing and mode registers
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            setup_r <= {NUM_CS{SMWT_SETUP_RST}};
            pulse_r <= {NUM_CS{SMWT_PULSE_RST}};
            cycle_r <= {NUM_CS{SMWT_CYCLE_RST}};
            mode_r  <= {NUM_CS{SMWT_MODE_RST}};
        end else if (prot_hit && !blk_wr) begin
            // Protected writes fall through untouched
            case (reg_sel)
                2'h0: setup_r[reg_cs] <= REG_WDATA & SMWT_SETUP_MASK;
                2'h1: pulse_r[reg_cs] <= REG_WDATA & SMWT_PULSE_MASK;
                2'h2: cycle_r[reg_cs] <= REG_WDATA & SMWT_CYCLE_MASK;
                2'h3: mode_r[reg_cs]  <= REG_WDATA & SMWT_MODE_MASK;
                default: mode_r[reg_cs] <= mode_r[reg_cs];
            endcase
        end
    end

    // Protection control and status
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            wprot_enable_r  <= 1'b0;
            wpvf_r  <= 1'b0;
            wpsrc_r <= '0;
        end else begin
            if (REG_WR && (REG_ADDR == SMWT_OFS_WPMODE)) begin
                wprot_enable_r <= REG_WDATA[SMWT_WPROT_ENABLE_BIT];
            end
            // A new violation wins over the clearing read
            if (blk_wr) begin
                wpvf_r  <= 1'b1;
                wpsrc_r <= {8'h00, REG_ADDR};
            end else if (REG_RD && (REG_ADDR == SMWT_OFS_WPSTAT)) begin
                wpvf_r <= 1'b0;
            end
        end
    end

    // Read data, one clock after the strobe; unmapped reads give zero
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata_r <= '0;
        end else if (!REG_RD) begin
            rdata_r <= '0;
        end else if (cs_hit) begin
            case (reg_sel)
                2'h0: rdata_r <= setup_r[reg_cs];
                2'h1: rdata_r <= pulse_r[reg_cs];
                2'h2: rdata_r <= cycle_r[reg_cs];
                2'h3: rdata_r <= mode_r[reg_cs];
                default: rdata_r <= '0;
            endcase
        end else if (REG_ADDR == SMWT_OFS_WPMODE) begin
            rdata_r <= {31'h0, wprot_enable_r};
        end else if (REG_ADDR == SMWT_OFS_WPSTAT) begin
            rdata_r <= {8'h00, wpsrc_r, 7'h00, wpvf_r};
        end else begin
            rdata_r <= '0;
        end
    end

    // Port drive, all from flip-flops
    assign REG_RDATA     = rdata_r;
    assign WR_READY      = rdy_r;
    assign MEM_ADDR      = addr_r;
    assign MEM_DATA_O    = data_r;
    assign MEM_DATA_OE   = oe_r;
    assign MEM_WSTROBE_N = wsn_r;
    assign MEM_CS_N      = csn_r;

    // Helper: job start marker and strobe low run length
    logic                  start_r;
    logic [SMWT_CNT_W-1:0] low_len;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            start_r <= 1'b0;
            low_len <= '0;
        end else begin
            start_r <= (st_nxt == SMWT_RUN) && (c_nxt == '0);
            low_len <= wsn_r ? '0 : low_len + 10'h001;
        end
    end

    default clocking dclk @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // Protection steps
    sequence s_prot_wr;
        blk_wr;
    endsequence
    sequence s_flag_up(logic [7:0] a);
        wpvf_r && (wpsrc_r == {8'h00, a});
    endsequence

    AST_ADDR_FIRST: assert property (start_r && (cur_ws != '0) |-> wsn_r)
        else $error("Strobe moved with the address");
    AST_PULSE_LEN: assert property ($rose(wsn_r) && ($past(cur_ws) != '0)
        |-> (low_len == $past(cur_wp)))
        else $error("Strobe low time differs from pulse");
    AST_CS_SETUP: assert property (start_r && (smwt_set_eff(setup_r[job_r.cs],
        SMWT_CSW_LSB) != '0) |-> (csn_r == '1))
        else $error("Select fell with the address");
    AST_READY_LAST: assert property ((st_r == SMWT_RUN) && rdy_r |-> last)
        else $error("Ready before cycle end");
    AST_BACK2BACK: assert property ((st_r == SMWT_RUN) && last && acc && same_cs
        && (smwt_set_eff(setup_r[WR_REQ.cs], SMWT_WS_LSB) == '0) && !wsn_r
        |=> !wsn_r)
        else $error("Strobe released between joined writes");
    AST_OE_STROBE: assert property ((st_r == SMWT_RUN) && cur_wm && (c_r >= cur_ws)
        |-> oe_r)
        else $error("Data not driven after strobe setup");
    AST_OE_SELECT: assert property ((st_r == SMWT_RUN) && !cur_wm
        && (c_r < smwt_set_eff(setup_r[job_r.cs], SMWT_CSW_LSB)) |-> !oe_r)
        else $error("Data driven before select setup");
    AST_FLAG_SET: assert property (s_prot_wr |=> s_flag_up($past(REG_ADDR)))
        else $error("Violation not recorded");
    AST_FLAG_CLR: assert property (REG_RD && (REG_ADDR == SMWT_OFS_WPSTAT) && !blk_wr
        |=> !wpvf_r)
        else $error("Status read left flag set");
    AST_NO_CHANGE: assert property (s_prot_wr |=> $stable(setup_r) && $stable(pulse_r)
        && $stable(cycle_r) && $stable(mode_r))
        else $error("Protected register changed");
    // Only the zero-hold case; with a real hold the select may rise beside the strobe
    AST_ZERO_HOLD: assert property ($rose(wsn_r) && $past(cur_wm) && $past(st_r == SMWT_RUN)
        && $past(ext) && $past(last)
        |-> $stable(addr_r) && $stable(csn_r))
        else $error("Address or select moved at strobe rise");
endmodule
`default_nettype wire

/* tb/smwt_mem_model.sv */
// Behavioural asynchronous static memory watching the write pins
`timescale 1ns/10ps
`default_nettype none
module smwt_mem_model
    import smwt_pkg::*;
(
    // Sampling clock
    input  wire logic                   CLK,
    // Memory pins
    input  wire logic [SMWT_ADDR_W-1:0] MEM_ADDR,
    input  wire logic [SMWT_DATA_W-1:0] MEM_DATA_O,
    input  wire logic                   MEM_DATA_OE,
    input  wire logic                   MEM_WSTROBE_N,
    input  wire logic [3:0]             MEM_CS_N,
    // Last word stored
    output logic      [SMWT_ADDR_W-1:0] last_addr,
    output logic      [SMWT_DATA_W-1:0] last_data
);
    logic                   act_r;  // Strobe and a select both low
    logic [SMWT_ADDR_W-1:0] a_r;    // Address seen last clock
    logic [SMWT_DATA_W-1:0] d_r;    // Data seen last clock
    logic                   oe_r;   // Bus driven last clock

    initial begin
        act_r = 1'b0;
    end

    // Store on the edge that ends the overlap, as a real part latches
    always @(posedge CLK) begin
        if (act_r && !(!MEM_WSTROBE_N && !(&MEM_CS_N))) begin
            last_addr <= a_r;
            // Undriven bus returns junk, never the last good value
            last_data <= oe_r ? d_r : ~d_r;
        end
        act_r <= !MEM_WSTROBE_N && !(&MEM_CS_N);
        a_r <= MEM_ADDR;
        d_r <= MEM_DATA_O;
        oe_r <= MEM_DATA_OE;
    end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for register access and write waveforms
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top import smwt_pkg::*;;
    logic                   CLK, RST_B, REG_WR, REG_RD, WR_VALID, WR_READY;
    logic [7:0]             REG_ADDR;
    logic [31:0]            REG_WDATA, REG_RDATA;
    smwt_req_s              WR_REQ;
    logic [SMWT_ADDR_W-1:0] MEM_ADDR, last_addr;
    logic [SMWT_DATA_W-1:0] MEM_DATA_O, last_data;
    logic                   MEM_DATA_OE, MEM_WSTROBE_N;
    logic [3:0]             MEM_CS_N;
    int                     failures, n_tests, i;
    logic [31:0]            msk [4];   // Writable bits per register

    smwt_top #(.NUM_CS(4)) smwt_top_i (
        .CLK(CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
        .WR_VALID(WR_VALID), .WR_REQ(WR_REQ), .WR_READY(WR_READY),
        .MEM_ADDR(MEM_ADDR), .MEM_DATA_O(MEM_DATA_O), .MEM_DATA_OE(MEM_DATA_OE),
        .MEM_WSTROBE_N(MEM_WSTROBE_N), .MEM_CS_N(MEM_CS_N));

    smwt_mem_model smwt_mem_model_i (
        .CLK(CLK), .MEM_ADDR(MEM_ADDR), .MEM_DATA_O(MEM_DATA_O),
        .MEM_DATA_OE(MEM_DATA_OE), .MEM_WSTROBE_N(MEM_WSTROBE_N),
        .MEM_CS_N(MEM_CS_N), .last_addr(last_addr), .last_data(last_data));

    // 20 MHz clock
    initial begin
        CLK = 1'b0;
        forever #25 CLK = ~CLK;
    end

    // Verdict, shared by the main sequence and every timeout
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One-cycle register write
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK);
        REG_WR <= 1'b0;
        #1;
    endtask

    // One-cycle read; data looked at only in the following cycle
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1;
        `CHK(REG_RDATA, exp)
    endtask

    // Wait for the edge that takes the request, bounded
    task automatic wait_take();
        for (int k = 0; k < 2000; k++) begin
            @(posedge CLK);
            if (WR_READY === 1'b1) begin
                return;
            end
        end
        failures++;
        wrap_up();
    endtask

    // One write job, every position checked against the programmed timing
    task automatic run_job(input logic [1:0] cs, input logic [23:0] a, input logic [7:0] d,
                           input int ws, wp, css, csp, len, input logic md);
        WR_VALID <= 1'b1;
        WR_REQ <= '{cs: cs, addr: a, data: d};
        wait_take();
        WR_VALID <= 1'b0;
        for (int p = 0; p < len; p++) begin
            #1;
            `CHK(MEM_ADDR, a)
            `CHK(MEM_WSTROBE_N, !(p >= ws && p < ws + wp))
            `CHK(MEM_CS_N[cs], !(p >= css && p < css + csp))
            `CHK(MEM_DATA_OE, p >= (md ? ws : css))
            if (MEM_DATA_OE === 1'b1) `CHK(MEM_DATA_O, d)
            if (p == len - 1) `CHK(WR_READY, 1'b1)
            @(posedge CLK);
        end
        #1;
        `CHK({last_addr, last_data}, {a, d})
    endtask

    // Main sequence
    initial begin
        failures = 0;
        n_tests = 0;
        msk = '{SMWT_SETUP_MASK, SMWT_PULSE_MASK, SMWT_CYCLE_MASK, SMWT_MODE_MASK};
        RST_B = 1'b0;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        REG_ADDR = 8'h00;
        REG_WDATA = 32'h0;
        WR_VALID = 1'b0;
        WR_REQ = '0;
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        // Reset values of every chip select, then status and a hole
        for (i = 0; i < 4; i++) begin
            reg_rd(SMWT_CS_STRIDE * i + SMWT_OFS_SETUP, 32'h01010101);
            reg_rd(SMWT_CS_STRIDE * i + SMWT_OFS_PULSE, 32'h01010101);
            reg_rd(SMWT_CS_STRIDE * i + SMWT_OFS_CYCLE, 32'h00030003);
            reg_rd(SMWT_CS_STRIDE * i + SMWT_OFS_MODE, 32'h00000003);
        end
        reg_rd(SMWT_OFS_WPSTAT, 32'h0);
        reg_wr(8'hF0, 32'hFFFFFFFF);
        reg_rd(8'hF0, 32'h0);
        // Protected writes are dropped, flagged and named
        reg_wr(SMWT_OFS_WPMODE, 32'h1);
        for (i = 0; i < 4; i++) begin
            reg_wr(8'h20 + 8'(i * 4), 32'h0);
            reg_rd(SMWT_OFS_WPSTAT, 32'h1 | ((32'h20 + 32'(i * 4)) << 8));
            reg_rd(SMWT_OFS_WPSTAT, (32'h20 + 32'(i * 4)) << 8);
        end
        reg_rd(8'h20, 32'h01010101);
        reg_rd(8'h2C, 32'h00000003);
        reg_wr(SMWT_OFS_WPMODE, 32'h0);
        // Field widths: all ones reads back only the writable bits
        for (i = 0; i < 4; i++) begin
            reg_wr(8'h20 + 8'(i * 4), 32'hFFFFFFFF);
            reg_rd(8'h20 + 8'(i * 4), msk[i]);
        end
        // Default timing, strobe controlled
        run_job(2'h0, 24'h000123, 8'hA5, 1, 1, 1, 1, 3, 1'b1);
        // Select controlled, distinct select timing, nonzero setup
        reg_wr(8'h10, 32'h01010102);
        reg_wr(8'h14, 32'h01010503);
        reg_wr(8'h18, 32'h00030007);
        reg_wr(8'h1C, 32'h00000001);
        run_job(2'h1, 24'h5A5A5A, 8'h3C, 2, 3, 1, 5, 7, 1'b0);
        // Top bits of every code
        reg_wr(8'h30, 32'h01012021);
        reg_wr(8'h34, 32'h01014241);
        reg_wr(8'h38, 32'h00030105);
        run_job(2'h3, 24'hFFFFFF, 8'h81, 128 + 1, 256 + 1, 128, 256 + 2, 512 + 5, 1'b1);
        // Zero setup and hold: two jobs with no gap on one select
        reg_wr(8'h00, 32'h01010000);
        reg_wr(8'h04, 32'h01010202);
        reg_wr(8'h08, 32'h00030002);
        WR_VALID <= 1'b1;
        WR_REQ <= '{cs: 2'h0, addr: 24'h00AAAA, data: 8'h11};
        wait_take();
        WR_REQ <= '{cs: 2'h0, addr: 24'h00BBBB, data: 8'h22};
        for (i = 0; i < 4; i++) begin
            #1;
            `CHK({MEM_WSTROBE_N, MEM_CS_N[0]}, 2'b00)
            if (i == 1) `CHK(WR_READY, 1'b1)
            if (i == 2) `CHK(MEM_ADDR, 24'h00BBBB)
            @(posedge CLK);
            if (i == 1) WR_VALID <= 1'b0;
        end
        // Extra clock after a zero strobe hold keeps address and select
        #1;
        `CHK({MEM_WSTROBE_N, MEM_CS_N[0], MEM_ADDR}, {2'b10, 24'h00BBBB})
        @(posedge CLK);
        #1;
        `CHK(last_data, 8'h22)
        wrap_up();
    end
endmodule
`default_nettype wire
